// ---- lbmc_params.svh ----
// timing counts, reset values and slot figures for the local bus master control block
`ifndef LBMC_PARAMS_SVH
`define LBMC_PARAMS_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define LBMC_CLK_PERIOD_NS 50

// ----------------------------------------------------------------------------
// target ready window after address strobe
// ----------------------------------------------------------------------------
`define LBMC_RDY_MIN_NS 30
`define LBMC_RDY_MAX_NS 5000
`define LBMC_RDY_MIN_CYC ((`LBMC_RDY_MIN_NS + `LBMC_CLK_PERIOD_NS - 1) / `LBMC_CLK_PERIOD_NS)
`define LBMC_RDY_MAX_CYC (`LBMC_RDY_MAX_NS / `LBMC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// arbitration
// ----------------------------------------------------------------------------
`define LBMC_GRANT_LAT_NS 20000
`define LBMC_GRANT_LAT_CYC (`LBMC_GRANT_LAT_NS / `LBMC_CLK_PERIOD_NS)
`define LBMC_SLOTS 3
`define LBMC_SLOT_IDX_W 2
`define LBMC_TMO_W 8

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LBMC_GRANT_N_RST 3'h7
`define LBMC_TMO_RST 8'h00

`endif

// ---- lbmc_pkg.sv ----
// types shared by the local bus master control block
package lbmc_pkg;

	// ------------------------------------------------------------------------
	// isa command strobes, active high after inversion
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic memRd;
		logic memWr;
		logic ioRd;
		logic ioWr;
	} lbmc_cmd_s;

	// ------------------------------------------------------------------------
	// forwarding sequence
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		FWD_IDLE = 3'b000,
		FWD_ADS = 3'b001,
		FWD_CLAIM = 3'b010,
		FWD_WAIT_RDY = 3'b011,
		FWD_WAIT_END = 3'b100,
		FWD_RTN = 3'b101
	} lbmc_fwd_e;

endpackage : lbmc_pkg

// ---- lbmc_top.sv ----
// isa cycle forwarding onto the local bus and three-slot local master arbiter
// Functional notes
// - forwarded memory cycle starts with M/IO high, i/o cycle with M/IO low
// - memory cycle 16-bit only with early MEMCS16
// - command strobe synchronised before use
// - address strobe low for exactly one cycle
// - unclaimed cycle: idle, still pulse ready-return
// - claimed: steer data, wait target ready
// - target ready releases IOCHRDY
// - ready-return one cycle after command ends
// - isa i/o cycles always 8-bit
// - M/IO lowered once i/o command seen
// - three request/grant pairs, grant answers request
// - request released, grant removed
// - preempt by removing grant, master releases
// - grant latency within 20 us normally
// - hold IOCHRDY low on claim plus command
// - MEMCS16 follows target claim low
// - D/C held high during forwarded cycles
`timescale 1ns/1ps
`include "lbmc_params.svh"
`default_nettype none

module lbmc_top
	import lbmc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic isaMemRdN,
	input wire logic isaMemWrN,
	input wire logic isaIoRdN,
	input wire logic isaIoWrN,
	input wire logic target_claim_n,
	input wire logic target_ready_n,
	input wire logic [`LBMC_SLOTS-1:0] master_request_n,
	output logic adsN,
	output logic mioN,
	output logic wrN,
	output logic dcN,
	output logic memCs16N,
	output logic iochrdy,
	output logic xfer16,
	output logic isaToLocalOe,
	output logic localToIsaOe,
	output logic ready_return_n,
	output logic [`LBMC_SLOTS-1:0] master_grant_n
);

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	function automatic logic [`LBMC_SLOT_IDX_W-1:0] pickSlot(input logic [`LBMC_SLOTS-1:0] req);
		pickSlot = 2'h0;
		if (req[0]) begin
			pickSlot = 2'h0;
		end else if (req[1]) begin
			pickSlot = 2'h1;
		end else if (req[2]) begin
			pickSlot = 2'h2;
		end
	endfunction : pickSlot

	function automatic logic [`LBMC_SLOTS-1:0] slotMask(input logic [`LBMC_SLOT_IDX_W-1:0] idx);
		slotMask = 3'h0;
		slotMask[idx] = 1'b1;
	endfunction : slotMask

	// ------------------------------------------------------------------------
	// command strobe synchroniser
	// ------------------------------------------------------------------------
	lbmc_cmd_s cmdMeta_r;
	lbmc_cmd_s cmdSync_r;
	wire lbmc_cmd_s cmdRaw = '{memRd: ~isaMemRdN, memWr: ~isaMemWrN, ioRd: ~isaIoRdN,
		ioWr: ~isaIoWrN};

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmdMeta_r <= '0;
			cmdSync_r <= '0;
		end else begin
			cmdMeta_r <= cmdRaw;
			cmdSync_r <= cmdMeta_r;
		end
	end

	wire logic cmdAny = |cmdSync_r;
	wire logic cmdIo = cmdSync_r.ioRd | cmdSync_r.ioWr;
	wire logic cmdWrite = cmdSync_r.memWr | cmdSync_r.ioWr;

	// ------------------------------------------------------------------------
	// forwarding state machine
	// ------------------------------------------------------------------------
	lbmc_fwd_e fwd_r;
	lbmc_fwd_e fwd_nxt;
	logic [`LBMC_TMO_W-1:0] tmo_r;
	logic ownVld_r;
	logic isWrite_r;
	logic claimed_r;

	wire logic claimNow = ~target_claim_n;
	wire logic readyNow = ~target_ready_n;
	// a target that never answers would hang the isa master; give up after the max window
	wire logic tmoHit = (tmo_r == 8'(`LBMC_RDY_MAX_CYC));
	wire logic fwdIdle = (fwd_r == FWD_IDLE);

	always_comb begin
		fwd_nxt = fwd_r;
		case (fwd_r)
			FWD_IDLE: begin
				if (cmdAny && !ownVld_r) begin
					fwd_nxt = FWD_ADS;
				end
			end
			FWD_ADS: begin
				fwd_nxt = FWD_CLAIM;
			end
			FWD_CLAIM: begin
				fwd_nxt = claimNow ? FWD_WAIT_RDY : FWD_WAIT_END;
			end
			FWD_WAIT_RDY: begin
				if (readyNow || tmoHit) begin
					fwd_nxt = FWD_WAIT_END;
				end
			end
			FWD_WAIT_END: begin
				if (!cmdAny) begin
					fwd_nxt = FWD_RTN;
				end
			end
			FWD_RTN: begin
				fwd_nxt = FWD_IDLE;
			end
			default: begin
				fwd_nxt = FWD_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// forwarded cycle outputs
	// ------------------------------------------------------------------------
	wire logic startCyc = fwdIdle && (fwd_nxt == FWD_ADS);
	wire logic adsN_nxt = ~startCyc;
	// memory assumed until an i/o strobe has been seen
	wire logic mioN_nxt = fwdIdle ? ~(startCyc && cmdIo) : mioN;
	wire logic wrN_nxt = startCyc ? cmdWrite : (fwdIdle ? 1'b1 : wrN);
	wire logic xfer16_nxt = startCyc ? (!cmdIo && !memCs16N) : (fwdIdle ? 1'b0 : xfer16);
	wire logic holdRdy = claimNow && cmdAny && !fwdIdle && (fwd_r != FWD_RTN);
	wire logic iochrdy_nxt = (fwd_nxt == FWD_WAIT_RDY) ? 1'b0 :
		((fwd_r == FWD_CLAIM || fwd_r == FWD_ADS) && holdRdy) ? 1'b0 : 1'b1;
	wire logic dataSteer = (fwd_nxt == FWD_WAIT_RDY) || (claimed_r && fwd_nxt == FWD_WAIT_END);
	wire logic isaToLocal_nxt = dataSteer && isWrite_r;
	wire logic localToIsa_nxt = dataSteer && !isWrite_r;
	wire logic claimed_nxt = (fwd_r == FWD_CLAIM) ? claimNow : (fwdIdle ? 1'b0 : claimed_r);
	wire logic [`LBMC_TMO_W-1:0] tmo_nxt = (fwd_r == FWD_WAIT_RDY && !tmoHit) ?
		8'(tmo_r + 8'h01) : (fwd_r == FWD_WAIT_RDY ? tmo_r : `LBMC_TMO_RST);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fwd_r <= FWD_IDLE;
			tmo_r <= `LBMC_TMO_RST;
			isWrite_r <= 1'b1;
			claimed_r <= 1'b0;
			adsN <= 1'b1;
			mioN <= 1'b1;
			wrN <= 1'b1;
			dcN <= 1'b1;
			memCs16N <= 1'b1;
			iochrdy <= 1'b1;
			xfer16 <= 1'b0;
			isaToLocalOe <= 1'b0;
			localToIsaOe <= 1'b0;
			ready_return_n <= 1'b1;
		end else begin
			fwd_r <= fwd_nxt;
			tmo_r <= tmo_nxt;
			isWrite_r <= startCyc ? cmdWrite : isWrite_r;
			claimed_r <= claimed_nxt;
			adsN <= adsN_nxt;
			mioN <= mioN_nxt;
			wrN <= wrN_nxt;
			dcN <= 1'b1;
			memCs16N <= target_claim_n;
			iochrdy <= iochrdy_nxt;
			xfer16 <= xfer16_nxt;
			isaToLocalOe <= isaToLocal_nxt;
			localToIsaOe <= localToIsa_nxt;
			ready_return_n <= ~(fwd_nxt == FWD_RTN);
		end
	end

	// ------------------------------------------------------------------------
	// local master arbiter
	// ------------------------------------------------------------------------
	logic [`LBMC_SLOT_IDX_W-1:0] own_r;
	logic [`LBMC_SLOTS-1:0] reqAct;
	assign reqAct = ~master_request_n;

	// owner stays recorded after a preempt until it really lets go of its request
	wire logic [`LBMC_SLOTS-1:0] ownMask = slotMask(own_r);
	wire logic ownReq = |(reqAct & ownMask);
	wire logic [`LBMC_SLOTS-1:0] higherReq = reqAct & (ownMask - 3'h1);
	wire logic [`LBMC_SLOT_IDX_W-1:0] winner = pickSlot(reqAct);
	// no new grant while an isa cycle is forwarded; this is the latency that can pass 20 us
	wire logic newGrant = !ownVld_r && fwdIdle && !cmdAny && (|reqAct);
	wire logic release_ = ownVld_r && !ownReq;
	wire logic preempt = ownVld_r && ownReq && (|higherReq);
	wire logic ownVld_nxt = newGrant ? 1'b1 : (release_ ? 1'b0 : ownVld_r);
	wire logic [`LBMC_SLOT_IDX_W-1:0] own_nxt = newGrant ? winner : own_r;
	wire logic [`LBMC_SLOTS-1:0] grantN_nxt = newGrant ? ~slotMask(winner) :
		((release_ || preempt) ? `LBMC_GRANT_N_RST : master_grant_n);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ownVld_r <= 1'b0;
			own_r <= 2'h0;
			master_grant_n <= `LBMC_GRANT_N_RST;
		end else begin
			ownVld_r <= ownVld_nxt;
			own_r <= own_nxt;
			master_grant_n <= grantN_nxt;
		end
	end

endmodule : lbmc_top

`default_nettype wire

// ---- lbmc_asserts.sv ----
// concurrent checks on the ports of the local bus master control block
`timescale 1ns/1ps
`include "lbmc_params.svh"
`default_nettype none
module lbmc_asserts
	import lbmc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic isaMemRdN,
	input wire logic isaMemWrN,
	input wire logic isaIoRdN,
	input wire logic isaIoWrN,
	input wire logic target_claim_n,
	input wire logic target_ready_n,
	input wire logic [`LBMC_SLOTS-1:0] master_request_n,
	input wire logic adsN,
	input wire logic mioN,
	input wire logic wrN,
	input wire logic dcN,
	input wire logic memCs16N,
	input wire logic iochrdy,
	input wire logic xfer16,
	input wire logic isaToLocalOe,
	input wire logic localToIsaOe,
	input wire logic ready_return_n,
	input wire logic [`LBMC_SLOTS-1:0] master_grant_n
);
	wire logic cmdOff = &{isaMemRdN, isaMemWrN, isaIoRdN, isaIoWrN};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence claimSeen;
		$fell(adsN) ##1 !target_claim_n;
	endsequence
	ads_one_cycle_a: assert property (!adsN |=> adsN)
		else $error("address strobe longer than one cycle");
	ads_after_sync_a: assert property ($fell(adsN) |-> !$past(cmdOff, 2) && !$past(cmdOff, 3))
		else $error("address strobe before synchronised command");
	rtn_after_end_a: assert property (!ready_return_n |-> $past(cmdOff) && $past(cmdOff, 2))
		else $error("ready return before command ended");
	rtn_one_cycle_a: assert property (!ready_return_n |=> ready_return_n)
		else $error("ready return longer than one cycle");
	claim_steer_a: assert property (claimSeen |=> (wrN ? isaToLocalOe : localToIsaOe) && !iochrdy)
		else $error("claimed cycle not steered or not held");
	ready_release_a: assert property (!iochrdy && !target_ready_n |=> iochrdy)
		else $error("isa ready not released on target ready");
	io_narrow_a: assert property (!mioN |-> !xfer16)
		else $error("io cycle marked wide");
	cs16_follow_a: assert property (memCs16N == $past(target_claim_n))
		else $error("wide select does not follow claim");
	data_cycle_a: assert property (dcN)
		else $error("data or code line low");
	one_grant_a: assert property ($countones(~master_grant_n) <= 1)
		else $error("more than one grant");
	grant_drop_a: assert property (|(~master_grant_n & master_request_n)
		|=> (~master_grant_n & $past(~master_grant_n & master_request_n)) == '0)
		else $error("grant kept after request released");
	grant_to_req_a: assert property ((~master_grant_n & $past(master_grant_n)
		& $past(master_request_n)) == '0)
		else $error("grant given without request");
endmodule : lbmc_asserts
bind lbmc_top lbmc_asserts u_lbmc_asserts (.ref_clk, .reset_n, .isaMemRdN, .isaMemWrN,
	.isaIoRdN, .isaIoWrN, .target_claim_n, .target_ready_n, .master_request_n, .adsN, .mioN,
	.wrN, .dcN, .memCs16N, .iochrdy, .xfer16, .isaToLocalOe, .localToIsaOe, .ready_return_n,
	.master_grant_n);
`default_nettype wire

// ---- lbmc_target_model.sv ----
// behavioural local bus target answering forwarded cycles
`timescale 1ns/1ps
`default_nettype none
module lbmc_target_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic claimEn,
	input wire logic ioSel,
	input wire logic [7:0] rdyDelay,
	input wire logic adsN,
	input wire logic mioN,
	output logic target_claim_n,
	output logic target_ready_n
);
	logic [7:0] cnt_r;
	logic rdy_r;
	logic tog_r;
	// io targets only decode once the cycle is marked io
	wire logic claimed = claimEn & (ioSel ? ~mioN : mioN);
	assign target_claim_n = ~claimed;
	// undriven ready toggles so no stale level can be trusted
	assign target_ready_n = claimed ? ~rdy_r : tog_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
			rdy_r <= 1'b0;
			tog_r <= 1'b0;
		end else begin
			tog_r <= ~tog_r;
			rdy_r <= (cnt_r == 8'h01);
			if (!adsN && claimed) cnt_r <= rdyDelay;
			else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule : lbmc_target_model
`default_nettype wire

// ---- local_bus_master_control_test.sv ----
// self-checking bench for the local bus master control block
`timescale 1ns/1ps
`include "lbmc_params.svh"
`default_nettype none
module local_bus_master_control_test import lbmc_pkg::*;;
	logic ref_clk, reset_n, claimEn, ioSel, adsN, mioN, wrN, dcN, memCs16N, iochrdy, xfer16;
	logic i2l, l2i, rtnN, claimN, readyN;
	logic [7:0] rdyDelay;
	logic [2:0] req, gnt;
	logic [31:0] seed = 32'h0000_2103;
	logic [31:0] r;
	lbmc_cmd_s cmd;
	int num_errors = 0, check_count = 0, cyc = 0, k;
	lbmc_top u_lbmc_top (.ref_clk, .reset_n, .isaMemRdN(~cmd.memRd), .isaMemWrN(~cmd.memWr),
		.isaIoRdN(~cmd.ioRd), .isaIoWrN(~cmd.ioWr), .target_claim_n(claimN),
		.target_ready_n(readyN), .master_request_n(req), .adsN, .mioN, .wrN, .dcN, .memCs16N,
		.iochrdy, .xfer16, .isaToLocalOe(i2l), .localToIsaOe(l2i), .ready_return_n(rtnN),
		.master_grant_n(gnt));
	lbmc_target_model u_lbmc_target_model (.ref_clk, .reset_n, .claimEn, .ioSel, .rdyDelay,
		.adsN, .mioN, .target_claim_n(claimN), .target_ready_n(readyN));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [2:0] prio(input logic [2:0] q);
		return !q[0] ? 3'h6 : !q[1] ? 3'h5 : !q[2] ? 3'h3 : 3'h7;
	endfunction : prio
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic fwd(input int kind, input logic clm, input logic [7:0] d);
		int i;
		cmd = lbmc_cmd_s'(4'h8 >> kind);
		ioSel = kind[1];
		claimEn = clm;
		rdyDelay = d;
		for (i = 0; i < 10 && adsN !== 1'b0; i++) @(negedge ref_clk);
		chk("ads", adsN, 0);
		chk("mio", mioN, !kind[1]);
		chk("wr", wrN, kind[0]);
		chk("wide", xfer16, clm && !kind[1]);
		repeat (2) @(negedge ref_clk);
		if (clm) begin
			chk("hold", iochrdy, 0);
			chk("oe", {i2l, l2i}, kind[0] ? 2'h2 : 2'h1);
			for (i = 0; i < 120 && iochrdy !== 1'b1; i++) @(negedge ref_clk);
			// release must follow the target's ready, not the give-up count
			chk("relTime", 8'(i), d);
			chk("release", iochrdy, 1);
		end else begin
			chk("idle", {iochrdy, i2l, l2i}, 3'h4);
		end
		cmd = '0;
		for (i = 0; i < 10 && rtnN !== 1'b0; i++) @(negedge ref_clk);
		chk("rtn", rtnN, 0);
		claimEn = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : fwd
	task automatic arb(input logic [2:0] q, input logic [2:0] exp, input int n);
		// masters here run no bus cycles: nothing to drive or float, no ready to await
		req = q;
		repeat (n) @(negedge ref_clk);
		chk("grant", gnt, exp);
	endtask : arb
	task stop_test();
		if (num_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	initial begin
		cmd = '0;
		claimEn = 1'b0;
		ioSel = 1'b0;
		rdyDelay = 8'h02;
		req = 3'h7;
		reset_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		@(negedge ref_clk);
		chk("grantRst", gnt, 3'h7);
		for (k = 0; k < 8; k++) fwd(k % 4, k >= 4, 8'h02);
		fwd(1, 1'b1, 8'h50);
		repeat (12) begin
			r = rnd();
			fwd(r[1:0], r[2], {3'h0, r[7:3]} + 8'h02);
		end
		repeat (16) begin
			r = rnd();
			arb(r[2:0], prio(r[2:0]), 2);
			arb(3'h7, 3'h7, 3);
		end
		// slot 0 preempts slot 2, which must drop before the new grant
		arb(3'h3, 3'h3, 2);
		arb(3'h2, 3'h7, 3);
		arb(3'h6, 3'h6, 3);
		arb(3'h7, 3'h7, 3);
		stop_test();
	end
endmodule : local_bus_master_control_test
`default_nettype wire
